// >>> hw/hsd_mask_timer.sv
// Purpose: per-channel start-up blanking timer for over-current detection
// Assumes: i_on is the synchronous driver-on command
// Notes: o_blank high for CYC+1 cycles from the rising edge of i_on
module hsd_mask_timer
    import hsd_pkg::*;
#(
    parameter int CYC = OCM_CYC
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // control
    input wire logic i_on,
    input wire logic i_mask_en,
    output logic o_blank
);
    logic on_d_r;
    logic [OCM_W-1:0] cnt_r;

    // restart on each switch-on edge while i_mask_en is set, clear while off, count down otherwise
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            on_d_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            on_d_r <= i_on;
            if (i_on && !on_d_r && i_mask_en)
                cnt_r <= OCM_W'(CYC);
            else if (!i_on)
                cnt_r <= '0;
            else if (cnt_r != '0)
                cnt_r <= cnt_r - 1'b1;
        end
    end

    // blank also in the edge cycle itself, before the count loads
    assign o_blank = i_mask_en && i_on && (!on_d_r || cnt_r != '0);
endmodule

// >>> hw/hsd_pkg.sv
// Purpose: shared constants and types of the high-side driver control block
// Assumes: 32-bit axi4-lite register bus, 50 MHz system clock
// Notes: register word offsets are byte addresses
package hsd_pkg;
    localparam int NCH = 2;
    localparam int AW = 4;
    // register byte offsets
    localparam logic [AW-1:0] OFF_DATA = 4'h0;
    localparam logic [AW-1:0] OFF_CTRL = 4'h4;
    localparam logic [AW-1:0] OFF_FLAG = 4'h8;
    localparam logic [AW-1:0] OFF_MASK = 4'hc;
    // control register field positions
    localparam int CTRL_EN_POS = 0;
    localparam int CTRL_OCME_POS = 2;
    // reset values
    localparam logic [NCH-1:0] RST_DATA = 2'h0;
    localparam logic [NCH-1:0] RST_EN = 2'h0;
    localparam logic [NCH-1:0] RST_OCME = 2'h0;
    localparam logic [NCH-1:0] RST_FLAG = 2'h0;
    localparam logic RST_IE = 1'h0;
    // over-current mask interval
    localparam int CLK_HZ = 50_000_000;
    localparam int OCM_TIME_NS = 1000;
    localparam int OCM_CYC = (OCM_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int OCM_W = $clog2(OCM_CYC + 1);
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // per-channel driver state
    typedef struct packed {
        logic [NCH-1:0] drive;
        logic [NCH-1:0] flag;
    } hsd_chan_t;
endpackage

// >>> hw/hsd_sync.sv
// Purpose: two-flop synchroniser for a vector of pin levels
// Assumes: inputs are asynchronous to i_clk_sys
// Notes: first stage is read only by the second stage
module hsd_sync #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] s1_r;

    // two stages guard against metastability
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_r <= '0;
            o_q <= '0;
        end else begin
            s1_r <= i_d;
            o_q <= s1_r;
        end
    end
endmodule

// >>> hw/hsd_top.sv
// Purpose: control logic of two high-side load drivers with over-current shutdown
// Assumes: axi4-lite slave on i_clk_sys; i_src_sel and i_alt_src from the routing unit
// Notes: map 0x0 data, 0x4 control, 0x8 flags, 0xc interrupt mask
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
module hsd_top
    import hsd_pkg::*;
#(
    parameter int OCM_CYCLES = OCM_CYC
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // axi4-lite write address and data
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [AW-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // axi4-lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // axi4-lite read
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [AW-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // system mode and routing
    input wire logic i_stop,
    input wire logic [hsd_pkg::NCH-1:0] i_src_sel,
    input wire logic [hsd_pkg::NCH-1:0] i_alt_src,
    // analog interface
    input wire logic [hsd_pkg::NCH-1:0] i_oc_det,
    output logic [hsd_pkg::NCH-1:0] o_drv_en,
    output logic [hsd_pkg::NCH-1:0] o_drv_on,
    // interrupt
    output logic o_irq
);
    import hsd_pkg::*;

    logic [NCH-1:0] data_r;
    logic [NCH-1:0] en_r;
    logic [NCH-1:0] ocme_r;
    logic [NCH-1:0] flag_r;
    logic ie_r;
    logic stop_d_r;
    logic [NCH-1:0] oc_sync;
    logic [NCH-1:0] blank;
    logic [NCH-1:0] src_val;
    logic [NCH-1:0] oc_evt;
    hsd_chan_t chan;
    logic aw_held_r;
    logic w_held_r;
    logic [AW-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic commit;
    logic wr_data;
    logic wr_ctrl;
    logic wr_flag;
    logic wr_mask;
    logic wr_ok;
    logic [31:0] rd_val;
    logic rd_ok;

    // over-current pins cross into the bus clock domain
    hsd_sync #(.W(NCH)) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_d(i_oc_det),
        .o_q(oc_sync)
    );

    // per-channel source select, blanking and event detect
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            // routed source or data bit; 1 means on
            assign src_val[g] = i_src_sel[g] ? i_alt_src[g] : data_r[g];
            hsd_mask_timer #(.CYC(OCM_CYCLES)) u_mask (
                .i_clk_sys(i_clk_sys),
                .i_rst_b(i_rst_b),
                .i_on(en_r[g] && src_val[g]),
                .i_mask_en(ocme_r[g]),
                .o_blank(blank[g])
            );
            assign oc_evt[g] = oc_sync[g] && o_drv_on[g] && !blank[g];
        end
    endgenerate

    // decode from the held copies, so the effect follows the captured beat, not the live bus
    // the register effect happens once, in the cycle the response is raised
    assign commit = aw_held_r && w_held_r && !o_bvalid;
    assign wr_data = commit && awaddr_r == OFF_DATA && wstrb_r[0];
    assign wr_ctrl = commit && awaddr_r == OFF_CTRL && wstrb_r[0];
    assign wr_flag = commit && awaddr_r == OFF_FLAG && wstrb_r[0];
    assign wr_mask = commit && awaddr_r == OFF_MASK && wstrb_r[0];
    assign wr_ok = awaddr_r == OFF_DATA || awaddr_r == OFF_CTRL ||
        awaddr_r == OFF_FLAG || awaddr_r == OFF_MASK;

    // write channel capture; address and data may arrive in either order
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
        end else begin
            // ready pulses one cycle on acceptance
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            if (i_awvalid && !aw_held_r && !o_awready && !o_bvalid) begin
                aw_held_r <= 1'b1;
                awaddr_r <= i_awaddr;
                o_awready <= 1'b1;
            end
            if (i_wvalid && !w_held_r && !o_wready && !o_bvalid) begin
                w_held_r <= 1'b1;
                wdata_r <= i_wdata;
                wstrb_r <= i_wstrb;
                o_wready <= 1'b1;
            end
            if (aw_held_r && w_held_r && !o_bvalid) begin
                o_bvalid <= 1'b1;
                o_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
            end
        end
    end

    // data register, cleared on the edge into stop
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            data_r <= RST_DATA;
            stop_d_r <= 1'b0;
        end else begin
            stop_d_r <= i_stop;
            if (i_stop && !stop_d_r)
                data_r <= '0;
            else if (wr_data)
                data_r <= wdata_r[NCH-1:0];
        end
    end

    // control register: enables and mask enables
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            en_r <= RST_EN;
            ocme_r <= RST_OCME;
        end else if (wr_ctrl) begin
            en_r <= wdata_r[CTRL_EN_POS +: NCH];
            for (int i = 0; i < NCH; i++)
                if (!en_r[i])
                    ocme_r[i] <= wdata_r[CTRL_OCME_POS + i];
        end
    end

    // sticky flags: set beats a simultaneous write-one clear, stop has no effect
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            flag_r <= RST_FLAG;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (oc_evt[i])
                    flag_r[i] <= 1'b1;
                else if (wr_flag && wdata_r[i])
                    flag_r[i] <= 1'b0;
            end
        end
    end

    // interrupt enable register
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b)
            ie_r <= RST_IE;
        else if (wr_mask)
            ie_r <= wdata_r[0];
    end

    // driver outputs: flag forces off, clearing returns to source
    always_comb begin
        chan.flag = flag_r;
        chan.drive = en_r & src_val & ~flag_r;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_drv_en <= '0;
            o_drv_on <= '0;
            o_irq <= 1'b0;
        end else begin
            o_drv_en <= en_r;
            o_drv_on <= chan.drive;
            o_irq <= ie_r && (|chan.flag) && !i_stop;
        end
    end

    // read mux; data bits show the routed source while enabled
    always_comb begin
        rd_val = '0;
        rd_ok = 1'b1;
        unique case (i_araddr)
            OFF_DATA: rd_val[NCH-1:0] = (en_r & src_val) | (~en_r & data_r);
            OFF_CTRL: begin
                rd_val[CTRL_EN_POS +: NCH] = en_r;
                rd_val[CTRL_OCME_POS +: NCH] = ocme_r;
            end
            OFF_FLAG: rd_val[NCH-1:0] = flag_r;
            OFF_MASK: rd_val[0] = ie_r;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= RESP_OKAY;
        end else begin
            o_arready <= 1'b0;
            if (i_arvalid && !o_arready && !o_rvalid) begin
                o_arready <= 1'b1;
                o_rvalid <= 1'b1;
                o_rdata <= rd_val;
                o_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // driver output checks
    a_flag_forces_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        |flag_r |=> (o_drv_on & $past(flag_r)) == '0)
        else $error("driver on while flagged");
    a_drive_data: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (en_r[0] && !i_src_sel[0] && !flag_r[0]) |=> o_drv_on[0] == $past(data_r[0]))
        else $error("driver does not follow its data bit");
    a_alt_source: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (en_r[1] && i_src_sel[1] && !flag_r[1]) |=> o_drv_on[1] == $past(i_alt_src[1]))
        else $error("driver does not follow its routed source");
    a_clear_returns: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        ($fell(flag_r[0]) && en_r[0] && src_val[0]) |=> o_drv_on[0])
        else $error("driver not returned after flag clear");

    // flag and over-current checks
    a_oc_sets_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        oc_evt[0] |=> flag_r[0])
        else $error("over-current did not set flag");
    a_oc_flag_ch1: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        oc_evt[1] |=> flag_r[1])
        else $error("over-current did not set flag of channel 1");
    a_sync_delay: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        oc_sync[0] |-> $past(i_oc_det[0], 2))
        else $error("over-current seen before two sync stages");
    a_blank_no_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (blank[0] && !flag_r[0]) |=> !flag_r[0])
        else $error("flag set during blanking");
    a_flag_w1c: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (wr_flag && !wdata_r[0] && flag_r[0]) |=> flag_r[0])
        else $error("flag cleared by writing zero");
    a_flag_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (wr_flag && wdata_r[0] && !oc_evt[0]) |=> !flag_r[0])
        else $error("flag not cleared by writing one");
    a_flag_stop_keep: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        ($rose(i_stop) && !(|oc_evt) && !commit) |=> flag_r == $past(flag_r))
        else $error("flags changed on stop entry");

    // interrupt checks
    a_irq_run_only: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        $past(i_stop) |-> !o_irq)
        else $error("irq in stop");
    a_irq_cause: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (ie_r && |flag_r && !i_stop) |=> o_irq)
        else $error("irq missing");
    a_irq_needs_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !(|flag_r) |=> !o_irq)
        else $error("irq without a flag");

    // register checks
    a_stop_clears: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        $rose(i_stop) |=> data_r == '0)
        else $error("data not cleared on stop");
    a_data_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (wr_data && !(i_stop && !stop_d_r)) |=> data_r[0] == $past(wdata_r[0]))
        else $error("data write lost");
    a_ocme_locked: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        ($changed(ocme_r) && !$past(commit)) |-> 1'b0)
        else $error("mask enable changed outside write");
    a_ocme_en_lock: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (en_r[0] && !$rose(en_r[0])) |=> ocme_r[0] == $past(ocme_r[0]))
        else $error("mask enable written while enabled");
    a_read_stored: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_arvalid && !o_arready && !o_rvalid && i_araddr == OFF_DATA && !en_r[0])
        |=> o_rdata[0] == $past(data_r[0]))
        else $error("stored data bit not returned while disabled");
    a_read_source: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_arvalid && !o_arready && !o_rvalid && i_araddr == OFF_DATA && en_r[1] &&
        i_src_sel[1]) |=> o_rdata[1] == $past(i_alt_src[1]))
        else $error("routed source not returned while enabled");

    // scenario coverage
    c_oc_trip: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) $rose(flag_r[0]));
    c_stop_flag: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        $rose(i_stop) && |flag_r);
    c_irq: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) $rose(o_irq));
    c_blank: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) blank[0] && oc_sync[0]);
    c_alt_src: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        o_drv_on[1] && i_src_sel[1]);
endmodule

// >>> tb/hsd_load_model.sv
// Purpose: behavioural model of the two analog high-side switches and their loads
// Assumes: i_short is set by the bench to make a load draw too much current
// Notes: detector reports only while the switch is on, as a real sense amp would
module hsd_load_model (
    // switch commands from the block
    input wire logic [1:0] i_drv_en,
    input wire logic [1:0] i_drv_on,
    // bench control
    input wire logic [1:0] i_short,
    // detector output
    output logic [1:0] o_oc_det
);
    timeunit 1ns;
    timeprecision 1ps;
    // analog delay keeps the detector off the clock edge, so sync is exercised
    assign #3 o_oc_det = i_drv_on & i_drv_en & i_short;
endmodule

// >>> tb/tb.sv
// Purpose: self-checking bench of the high-side driver control block
// Assumes: mask interval shortened to 20 cycles through the parameter
// Notes: every register access goes through the axi4-lite tasks
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch at %0t: got %h exp %h", $time, got, exp); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import hsd_pkg::*;
    localparam int OCM = 20;
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, i_stop = 1'b0;
    logic [AW-1:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rd_d;
    logic [1:0] sel = '0, alt = '0, short = '0, oc, en, on, bresp, rresp, rr;
    logic awr, wr_r, bv, arr, rv, irq;
    logic [31:0] rdata;
    logic [1:0] wexp = RESP_OKAY;
    int error_cnt = 0;
    int compares = 0;
    // 50 MHz system clock
    always #10 i_clk_sys = ~i_clk_sys;
    hsd_top #(.OCM_CYCLES(OCM)) i_hsd_top (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv),
        .o_wready(wr_r), .i_wdata(wd), .i_wstrb(4'hf), .o_bvalid(bv), .i_bready(bry),
        .o_bresp(bresp), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara),
        .o_rvalid(rv), .i_rready(rry), .o_rdata(rdata), .o_rresp(rresp),
        .i_stop(i_stop), .i_src_sel(sel), .i_alt_src(alt), .i_oc_det(oc),
        .o_drv_en(en), .o_drv_on(on), .o_irq(irq));
    hsd_load_model i_hsd_load_model (.i_drv_en(en), .i_drv_on(on), .i_short(short),
        .o_oc_det(oc));
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    // write: offer address and data together, drop each when taken
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        int k;
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge i_clk_sys);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_r) wv <= 1'b0;
            if (bv) break;
        end
        bry <= 1'b0;
        `CHK(k < 100, 1'b1)
        `CHK(bresp, wexp)
        @(posedge i_clk_sys);
    endtask
    // read: hold rready until the data word is seen
    task automatic rd(input logic [AW-1:0] a);
        int k;
        ara <= a; arv <= 1'b1; rry <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge i_clk_sys);
            if (arv && arr) arv <= 1'b0;
            if (rv) break;
        end
        rd_d = rdata; rr = rresp;
        `CHK(k < 100, 1'b1)
        rry <= 1'b0;
        @(posedge i_clk_sys);
    endtask
    // all registers clear after reset, unmapped place refused
    task automatic t_reset;
        rd(OFF_DATA); `CHK(rd_d, 32'h0)
        rd(OFF_CTRL); `CHK(rd_d, 32'h0)
        rd(OFF_FLAG); `CHK(rd_d, 32'h0)
        rd(OFF_MASK); `CHK(rd_d, 32'h0)
        rd(4'h2); `CHK(rr, RESP_SLVERR)
        wexp = RESP_SLVERR;
        wr(4'h2, 32'h3);
        wexp = RESP_OKAY;
        rd(OFF_DATA); `CHK(rd_d, 32'h0)
        `CHK({en, on, irq}, 5'h0)
    endtask
    // data bits and routed sources as control, read-back source per enable
    task automatic t_source;
        wr(OFF_CTRL, 32'h3); cyc(5);
        wr(OFF_DATA, 32'h3); cyc(3);
        `CHK(en, 2'h3)
        `CHK(on, 2'h3)
        sel <= 2'h2; alt <= 2'h0; cyc(3);
        `CHK(on, 2'h1)
        rd(OFF_DATA); `CHK(rd_d, 32'h1)
        alt <= 2'h2; cyc(3);
        `CHK(on, 2'h3)
        wr(OFF_DATA, 32'h2); cyc(2);
        `CHK(on, 2'h2)
        wr(OFF_CTRL, 32'h0); cyc(2);
        rd(OFF_DATA); `CHK(rd_d, 32'h2)
        `CHK(on, 2'h0)
        sel <= 2'h0; alt <= 2'h0;
    endtask
    // over-current shutdown, flag handling, interrupt and stop mode
    task automatic t_overcurrent;
        wr(OFF_CTRL, 32'h1); wr(OFF_MASK, 32'h1); cyc(5);
        wr(OFF_DATA, 32'h1); short <= 2'h1; cyc(10);
        `CHK(on, 2'h0)
        `CHK(irq, 1'b1)
        rd(OFF_FLAG); `CHK(rd_d, 32'h1)
        short <= 2'h0;
        wr(OFF_FLAG, 32'h0); rd(OFF_FLAG); `CHK(rd_d, 32'h1)
        i_stop <= 1'b1; cyc(3);
        `CHK(irq, 1'b0)
        i_stop <= 1'b0; cyc(3);
        `CHK(irq, 1'b1)
        rd(OFF_FLAG); `CHK(rd_d, 32'h1)
        rd(OFF_DATA); `CHK(rd_d, 32'h0)
        wr(OFF_DATA, 32'h1); cyc(2);
        `CHK(on, 2'h0)
        wr(OFF_MASK, 32'h0); cyc(2);
        `CHK(irq, 1'b0)
        wr(OFF_FLAG, 32'h1); rd(OFF_FLAG); `CHK(rd_d, 32'h0)
        cyc(2);
        `CHK(on, 2'h1)
        wr(OFF_DATA, 32'h0); wr(OFF_CTRL, 32'h0);
    endtask
    // start-up blanking, mask bit locked while enabled
    task automatic t_blank;
        wr(OFF_CTRL, 32'h4); rd(OFF_CTRL); `CHK(rd_d, 32'h4)
        wr(OFF_CTRL, 32'h5); wr(OFF_CTRL, 32'h1);
        rd(OFF_CTRL); `CHK(rd_d, 32'h5)
        short <= 2'h1; cyc(5);
        wr(OFF_DATA, 32'h1); cyc(8);
        `CHK(on, 2'h1)
        rd(OFF_FLAG); `CHK(rd_d, 32'h0)
        cyc(OCM + 10);
        rd(OFF_FLAG); `CHK(rd_d, 32'h1)
        `CHK(on, 2'h0)
        short <= 2'h0;
        // second channel trips without blanking, then both flags clear together
        wr(OFF_CTRL, 32'h3); wr(OFF_DATA, 32'h2);
        short <= 2'h2; cyc(10);
        rd(OFF_FLAG); `CHK(rd_d, 32'h3)
        `CHK(on, 2'h0)
        short <= 2'h0;
        wr(OFF_FLAG, 32'h3); cyc(2);
        `CHK(on, 2'h2)
    endtask
    // one verdict for normal end and for the watchdog
    task automatic wrap_up;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // watchdog sized well above the few hundred cycles the tests need
    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end
    // main sequence
    initial begin
        cyc(4);
        i_rst_b <= 1'b1;
        cyc(1);
        t_reset();
        t_source();
        t_overcurrent();
        t_blank();
        wrap_up();
    end
endmodule
